/* design/fan_source_alert_mask_regs.sv */
// Purpose: Fan behaviour, interrupt mask and local limit registers behind a two-wire bus
// Assumes: Bus pins and measurement inputs are synchronous to clock_i
// Notes:   Status bits are sticky; the set wins over a clear in the same cycle
`timescale 1ns/1ps
module fan_source_alert_mask_regs
   import fan_regs_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = 7'h2C  // Arbitrary value, set per board
)(
   // Clock and reset
   input  wire logic                            clock_i,
   input  wire logic                            rstn_i,
   // Serial management bus
   input  wire logic                            scl_i,
   input  wire logic                            sda_i,
   output logic                                 sda_o,
   output logic                                 sda_oe_o,
   // Alert pin, open drain, low when driven
   output logic                                 alert_o,
   output logic                                 alert_oe_o,
   // Local measurement
   input  wire logic [fan_regs_pkg::DW-1:0]     local_temp_i,
   input  wire logic                            local_conv_done_i,
   // Status sources outside this slice
   input  wire logic [5:0]                      remote_event_i,
   input  wire logic [2:0]                      overtemp_event_i,
   input  wire logic [2:0]                      fan_fault_event_i,
   input  wire logic                            status_clear_i,
   // Configuration held elsewhere
   input  wire logic                            sw_reset_i,
   input  wire logic                            config_lock_i,
   input  wire logic                            alert_comparator_mode_i,
   input  wire logic [fan_regs_pkg::QLEN_W-1:0] fault_queue_len_i,
   // Fan control
   output logic                                 fan_one_off_o,
   output logic                                 fan_two_off_o,
   output logic [fan_regs_pkg::SEL_W-1:0]       fan_one_source_select_o,
   output logic [fan_regs_pkg::SEL_W-1:0]       fan_two_source_select_o,
   output logic                                 fan_one_full_speed_o,
   output logic                                 fan_two_full_speed_o,
   // Local limit status
   output logic                                 local_high_status_o,
   output logic                                 local_low_status_o
);
   import fan_regs_pkg::*;

   alert_if al();

   smb_state_t        state_r;
   logic              scl_q_r;
   logic              sda_q_r;
   logic [3:0]        bit_cnt_r;
   logic [7:0]        shift_r;
   logic [7:0]        ptr_r;
   logic [7:0]        rdata;
   logic              rw_r;
   logic              sda_oe_r;
   logic              wr_stb_r;
   logic [7:0]        fan_bhv_r;
   logic [7:0]        mask1_r;
   logic [7:0]        mask2_r;
   logic [7:0]        mask3_r;
   logic [7:0]        high_lim_r;
   logic [7:0]        low_lim_r;
   logic [7:0]        status1_r;
   logic [7:0]        status2_r;
   logic [7:0]        status3_r;
   logic [7:0]        set1;
   logic [7:0]        set2;
   logic [7:0]        set3;
   logic              above_high;
   logic              below_low;
   logic [LIMIT_CH-1:0] oor;
   logic [LIMIT_CH-1:0] met;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_det;
   logic              stop_det;
   logic              addr_match;
   logic              byte_end;
   logic              ack_end;
   logic              tx_load;

   // ----------------------------------------------------------------
   // Bus line edges
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_i;
         sda_q_r <= sda_i;
      end
   end

   assign scl_rise   = scl_i & ~scl_q_r;
   assign scl_fall   = ~scl_i & scl_q_r;
   assign start_det  = scl_i & scl_q_r & sda_q_r & ~sda_i;
   assign stop_det   = scl_i & scl_q_r & ~sda_q_r & sda_i;
   assign addr_match = (shift_r[7:1] == BUS_ADDR);
   assign byte_end   = scl_fall && (bit_cnt_r == BIT_LAST);
   assign ack_end    = scl_fall && (bit_cnt_r == BIT_ACK);
   assign tx_load    = ack_end && (((state_r == ST_ADDR) && rw_r) || (state_r == ST_RDATA));

   // ----------------------------------------------------------------
   // Transfer state
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_r <= ST_IDLE;
      end else if (start_det) begin
         state_r <= ST_ADDR;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
      end else if (byte_end) begin
         if ((state_r == ST_ADDR) && !addr_match) begin
            state_r <= ST_IDLE;
         end
      end else if (ack_end) begin
         case (state_r)
            ST_ADDR:  state_r <= rw_r ? ST_RDATA : ST_PTR;
            ST_PTR:   state_r <= ST_WDATA;
            default:  state_r <= state_r;
         endcase
      end else if (scl_rise && (bit_cnt_r == BIT_ACK) && (state_r == ST_RDATA) && sda_i) begin
         // Master declined more data
         state_r <= ST_IDLE;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         bit_cnt_r <= BIT_FIRST;
      end else if (start_det) begin
         bit_cnt_r <= '1; // Fall after a start is no bit; it wraps to bit 0
      end else if (scl_fall && (state_r != ST_IDLE)) begin
         bit_cnt_r <= (bit_cnt_r == BIT_ACK) ? BIT_FIRST : bit_cnt_r + BIT_STEP;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         rw_r <= 1'b0;
      end else if (byte_end && (state_r == ST_ADDR)) begin
         rw_r <= shift_r[0];
      end
   end

   // ----------------------------------------------------------------
   // Shift register, shared by receive and transmit
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         shift_r <= ZERO_BYTE;
      end else if (tx_load) begin
         shift_r <= rdata;
      end else if (scl_fall && (state_r == ST_RDATA) && (bit_cnt_r < BIT_LAST)) begin
         shift_r <= {shift_r[6:0], 1'b0};
      end else if (scl_rise && (bit_cnt_r < BIT_ACK) && (state_r != ST_IDLE)
                   && (state_r != ST_RDATA)) begin
         shift_r <= {shift_r[6:0], sda_i};
      end
   end

   // ----------------------------------------------------------------
   // Data line drive: acknowledge and read bits
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sda_oe_r <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe_r <= 1'b0;
      end else if (scl_fall) begin
         if (bit_cnt_r == BIT_LAST) begin
            sda_oe_r <= ((state_r == ST_ADDR) && addr_match)
                        || (state_r == ST_PTR) || (state_r == ST_WDATA);
         end else if (tx_load) begin
            sda_oe_r <= ~rdata[7];
         end else if ((state_r == ST_RDATA) && (bit_cnt_r < BIT_LAST)) begin
            sda_oe_r <= ~shift_r[6];
         end else begin
            sda_oe_r <= 1'b0;
         end
      end
   end

   assign sda_o    = 1'b0;
   assign sda_oe_o = sda_oe_r;

   // ----------------------------------------------------------------
   // Register pointer and write strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         ptr_r <= RST_PTR;
      end else if (byte_end && (state_r == ST_PTR)) begin
         ptr_r <= shift_r;
      end else if (byte_end && (state_r == ST_RDATA)) begin
         ptr_r <= ptr_r + PTR_STEP;
      end else if (ack_end && (state_r == ST_WDATA)) begin
         ptr_r <= ptr_r + PTR_STEP;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         wr_stb_r <= 1'b0;
      end else begin
         wr_stb_r <= byte_end && (state_r == ST_WDATA);
      end
   end

   // ----------------------------------------------------------------
   // Software-reset registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i || sw_reset_i) begin
         fan_bhv_r <= RST_FAN_BHV;
      end else if (wr_stb_r && (ptr_r == ADDR_FAN_BHV) && !config_lock_i) begin
         fan_bhv_r <= shift_r & WMASK_FAN_BHV;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i || sw_reset_i) begin
         mask1_r <= RST_MASK1;
      end else if (wr_stb_r && (ptr_r == ADDR_MASK1)) begin
         mask1_r <= shift_r & WMASK_MASK1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i || sw_reset_i) begin
         mask2_r <= RST_MASK2;
      end else if (wr_stb_r && (ptr_r == ADDR_MASK2)) begin
         mask2_r <= shift_r & WMASK_MASK2;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i || sw_reset_i) begin
         mask3_r <= RST_MASK3;
      end else if (wr_stb_r && (ptr_r == ADDR_MASK3)) begin
         mask3_r <= shift_r & WMASK_MASK3;
      end
   end

   // ----------------------------------------------------------------
   // Local limits: power-on reset only, never locked
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         high_lim_r <= RST_HIGH_LIM;
      end else if (wr_stb_r && (ptr_r == ADDR_HIGH_LIM)) begin
         high_lim_r <= shift_r;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         low_lim_r <= RST_LOW_LIM;
      end else if (wr_stb_r && (ptr_r == ADDR_LOW_LIM)) begin
         low_lim_r <= shift_r;
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      case (ptr_r)
         ADDR_FAN_BHV:  rdata = fan_bhv_r;
         ADDR_MASK1:    rdata = mask1_r;
         ADDR_MASK2:    rdata = mask2_r;
         ADDR_MASK3:    rdata = mask3_r;
         ADDR_HIGH_LIM: rdata = high_lim_r;
         ADDR_LOW_LIM:  rdata = low_lim_r;
         default:       rdata = ZERO_BYTE;
      endcase
   end

   // ----------------------------------------------------------------
   // Local limit checks and fault queues
   // ----------------------------------------------------------------
   assign above_high = (local_temp_i > high_lim_r);
   assign below_low  = (local_temp_i < low_lim_r);
   assign oor        = {above_high, below_low};

   for (genvar ch = 0; ch < LIMIT_CH; ch++) begin : g_queue
      fault_queue u_queue (
         .clock_i        (clock_i),
         .rstn_i         (rstn_i),
         .sample_i       (local_conv_done_i),
         .out_of_limit_i (oor[ch]),
         .queue_len_i    (fault_queue_len_i),
         .met_o          (met[ch])
      );
   end

   // ----------------------------------------------------------------
   // Sticky status, set wins over clear
   // ----------------------------------------------------------------
   assign set1 = {above_high & local_conv_done_i,
                  below_low & local_conv_done_i,
                  remote_event_i};
   assign set2 = {3'b000, overtemp_event_i, 2'b00};
   assign set3 = {fan_fault_event_i, 5'b00000};

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         status1_r <= ZERO_BYTE;
         status2_r <= ZERO_BYTE;
         status3_r <= ZERO_BYTE;
      end else begin
         status1_r <= (status_clear_i ? ZERO_BYTE : status1_r) | set1;
         status2_r <= (status_clear_i ? ZERO_BYTE : status2_r) | set2;
         status3_r <= (status_clear_i ? ZERO_BYTE : status3_r) | set3;
      end
   end

   // ----------------------------------------------------------------
   // Alert combining
   // ----------------------------------------------------------------
   assign al.status1   = status1_r;
   assign al.status2   = status2_r;
   assign al.status3   = status3_r;
   assign al.mask1     = mask1_r;
   assign al.mask2     = mask2_r;
   assign al.mask3     = mask3_r;
   assign al.qualify1  = {met, {6{1'b1}}};
   assign al.comp_mode = alert_comparator_mode_i;

   alert_gate u_gate (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .al      (al.gate)
   );

   assign alert_o    = 1'b0;
   assign alert_oe_o = al.alert;

   // ----------------------------------------------------------------
   // Fan control outputs
   // ----------------------------------------------------------------
   assign fan_two_off_o           = fan_bhv_r[FAN2_OFF_BIT];
   assign fan_one_off_o           = fan_bhv_r[FAN1_OFF_BIT];
   assign fan_two_source_select_o = fan_bhv_r[FAN2_SEL_LSB +: SEL_W];
   assign fan_one_source_select_o = fan_bhv_r[FAN1_SEL_LSB +: SEL_W];
   assign fan_two_full_speed_o    = (fan_bhv_r[FAN2_SEL_LSB +: SEL_W] == SRC_FULL);
   assign fan_one_full_speed_o    = (fan_bhv_r[FAN1_SEL_LSB +: SEL_W] == SRC_FULL);

   assign local_high_status_o = status1_r[7];
   assign local_low_status_o  = status1_r[6];

endmodule // fan_source_alert_mask_regs

/* include/fan_regs_pkg.sv */
// Purpose: Shared constants and types for the fan source and alert mask register slice
// Assumes: 8-bit registers reached over a two-wire serial management bus
// Notes:   Widths and encodings are common to the top and its helpers
package fan_regs_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          DW                = 8;
   localparam logic [7:0]  ADDR_FAN_BHV      = 8'h07;
   localparam logic [7:0]  ADDR_MASK1        = 8'h08;
   localparam logic [7:0]  ADDR_MASK2        = 8'h09;
   localparam logic [7:0]  ADDR_MASK3        = 8'h0A;
   localparam logic [7:0]  ADDR_HIGH_LIM     = 8'h0B;
   localparam logic [7:0]  ADDR_LOW_LIM      = 8'h0C;
   localparam logic [7:0]  PTR_STEP          = 8'h01;

   // ----------------------------------------------------------------
   // Reset values and writable bits
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_FAN_BHV       = 8'h09;
   localparam logic [7:0]  RST_MASK1         = 8'h52;
   localparam logic [7:0]  RST_MASK2         = 8'h18;
   localparam logic [7:0]  RST_MASK3         = 8'h00;
   localparam logic [7:0]  RST_HIGH_LIM      = 8'h8B;
   localparam logic [7:0]  RST_LOW_LIM       = 8'h54;
   localparam logic [7:0]  RST_PTR           = 8'h00;
   localparam logic [7:0]  ZERO_BYTE         = 8'h00;
   localparam logic [7:0]  WMASK_FAN_BHV     = 8'hCF;
   localparam logic [7:0]  WMASK_MASK1       = 8'hFF;
   localparam logic [7:0]  WMASK_MASK2       = 8'h1C;
   localparam logic [7:0]  WMASK_MASK3       = 8'hE0;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          FAN2_OFF_BIT      = 7;
   localparam int          FAN1_OFF_BIT      = 6;
   localparam int          FAN2_SEL_LSB      = 2;
   localparam int          FAN1_SEL_LSB      = 0;
   localparam int          SEL_W             = 2;
   localparam int          OT_STATE_BIT      = 2;
   localparam int          OT_EVENT_LSB      = 2;
   localparam int          FAN_FAULT_LSB     = 5;
   localparam int          LIMIT_CH          = 2;

   typedef enum logic [1:0] {
      SRC_LOCAL   = 2'b00,
      SRC_REMOTE1 = 2'b01,
      SRC_REMOTE2 = 2'b10,
      SRC_FULL    = 2'b11
   } fan_source_t;

   // ----------------------------------------------------------------
   // Fault queue lengths
   // ----------------------------------------------------------------
   localparam int          QLEN_W            = 4;
   localparam int          QCNT_W            = 3;
   localparam logic [2:0]  QUEUE_ONE         = 3'd1;
   localparam logic [2:0]  QUEUE_TWO         = 3'd2;
   localparam logic [2:0]  QUEUE_THREE       = 3'd3;
   localparam logic [2:0]  QUEUE_FOUR        = 3'd4;
   localparam logic [2:0]  QUEUE_STEP        = 3'd1;
   localparam logic [2:0]  QUEUE_CLEAR       = 3'd0;

   // ----------------------------------------------------------------
   // Serial bus framing
   // ----------------------------------------------------------------
   localparam logic [3:0]  BIT_FIRST         = 4'd0;
   localparam logic [3:0]  BIT_LAST          = 4'd7;
   localparam logic [3:0]  BIT_ACK           = 4'd8;
   localparam logic [3:0]  BIT_STEP          = 4'd1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WDATA,
      ST_RDATA
   } smb_state_t;

endpackage

/* include/alert_if.sv */
// Purpose: Carries status, masks and qualifiers from the register slice to the alert gate
// Assumes: One clock domain
// Notes:   Modport regs for the register side, gate for the combiner
`timescale 1ns/1ps
interface alert_if;
   logic [7:0] status1;
   logic [7:0] status2;
   logic [7:0] status3;
   logic [7:0] mask1;
   logic [7:0] mask2;
   logic [7:0] mask3;
   logic [7:0] qualify1;
   logic       comp_mode;
   logic       alert;

   modport regs (output status1, status2, status3, mask1, mask2, mask3,
                 output qualify1, comp_mode, input alert);
   modport gate (input status1, status2, status3, mask1, mask2, mask3,
                 input qualify1, comp_mode, output alert);
endinterface // alert_if

/* design/fault_queue.sv */
// Purpose: Counts consecutive out-of-limit conversions of one limit check
// Assumes: sample_i pulses once per completed conversion
// Notes:   met_o stays high while the run length reaches the programmed queue
`timescale 1ns/1ps
module fault_queue
   import fan_regs_pkg::*;
(
   // Clock and reset
   input  wire logic                          clock_i,
   input  wire logic                          rstn_i,
   // Measurement
   input  wire logic                          sample_i,
   input  wire logic                          out_of_limit_i,
   input  wire logic [fan_regs_pkg::QLEN_W-1:0] queue_len_i,
   // Result
   output logic                               met_o
);
   logic [QCNT_W-1:0] cnt_r;
   logic [QCNT_W-1:0] need;

   always_comb begin
      if (queue_len_i[3]) begin
         need = QUEUE_FOUR;
      end else if (queue_len_i[2]) begin
         need = QUEUE_THREE;
      end else if (queue_len_i[1]) begin
         need = QUEUE_TWO;
      end else begin
         need = QUEUE_ONE;
      end
   end

   // Run length saturates at the longest queue
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         cnt_r <= QUEUE_CLEAR;
      end else if (sample_i) begin
         if (!out_of_limit_i) begin
            cnt_r <= QUEUE_CLEAR;
         end else if (cnt_r != QUEUE_FOUR) begin
            cnt_r <= cnt_r + QUEUE_STEP;
         end
      end
   end

   assign met_o = (cnt_r >= need);

endmodule // fault_queue

/* design/alert_gate.sv */
// Purpose: Folds unmasked status bits into one registered alert level
// Assumes: Status and masks arrive through alert_if
// Notes:   The overtemperature state bit is ignored in comparator mode
`timescale 1ns/1ps
module alert_gate
   import fan_regs_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rstn_i,
   // Status and masks
   alert_if.gate     al
);
   logic [7:0] st2;
   logic       pending;

   always_comb begin
      st2 = al.status2;
      if (al.comp_mode) begin
         st2[OT_STATE_BIT] = 1'b0;
      end
      pending = |(al.status1 & ~al.mask1 & al.qualify1)
              | |(st2 & ~al.mask2)
              | |(al.status3 & ~al.mask3);
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         al.alert <= 1'b0;
      end else begin
         al.alert <= pending;
      end
   end

endmodule // alert_gate

/* testbench/smbus_host_model.sv */
// Purpose: Bus host model for register access
// Assumes: Each SCL phase lasts 2 clocks
// Notes:   Drives 1 to release the open-drain data line
`timescale 1ns/1ps
module smbus_host_model (
   input  wire logic clock_i,
   input  wire logic sda_i,
   output logic      scl_o = 1'b1,
   output logic      sda_o = 1'b1
);
   localparam logic [6:0] DEV = 7'h2C;  // Arbitrary value, matches the device default
   task automatic ph(input logic c, input logic d);
      {scl_o, sda_o} = {c, d};
      repeat (2) @(posedge clock_i);
      #1;
   endtask
   // One bit slot; (1,0) frames a START, (0,1) a STOP
   task automatic fr(input logic s, input logic e);
      ph(1'b0, sda_o);
      ph(1'b0, s);
      ph(1'b1, s);
      ph(1'b1, e);
   endtask
   task automatic by(input logic [7:0] d, output logic [7:0] o);
      logic [8:0] x;
      x = {d, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         fr(x[i], x[i]);
         x[i] = sda_i;
      end
      o = x[8:1];
   endtask
   task automatic xf(input logic r, input logic [7:0] p, input logic [7:0] d,
                     output logic [7:0] o);
      fr(1'b1, 1'b0);
      by({DEV, 1'b0}, o);
      by(p, o);
      if (r) begin
         fr(1'b1, 1'b0);
         by({DEV, 1'b1}, o);
      end
      by(r ? 8'hFF : d, o);
      fr(1'b0, 1'b1);
   endtask
endmodule // smbus_host_model

/* testbench/fan_regs_properties.sv */
// Purpose: Port properties of the fan register slice
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
module fan_regs_properties (
   input wire logic       clock_i, rstn_i, sw_reset_i, config_lock_i, status_clear_i,
   input wire logic       local_conv_done_i, alert_oe_o, local_high_status_o,
   input wire logic       local_low_status_o, fan_one_off_o, fan_two_off_o,
   input wire logic       fan_one_full_speed_o, fan_two_full_speed_o,
   input wire logic [1:0] fan_one_source_select_o, fan_two_source_select_o,
   input wire logic [2:0] overtemp_event_i, fan_fault_event_i,
   input wire logic [5:0] remote_event_i
);
   wire [5:0] fan = {fan_two_off_o, fan_one_off_o, fan_two_source_select_o,
                     fan_one_source_select_o};
   wire       quiet = !local_conv_done_i &&
                      !(|{remote_event_i, overtemp_event_i, fan_fault_event_i});
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   full_one_a: assert property (fan_one_full_speed_o == &fan_one_source_select_o)
      else $error("fan one full speed");
   full_two_a: assert property (fan_two_full_speed_o == &fan_two_source_select_o)
      else $error("fan two full speed");
   swrst_fan_a: assert property (sw_reset_i |=> fan == 6'h09)
      else $error("soft reset fan value");
   lock_hold_a: assert property (config_lock_i && !sw_reset_i |=> $stable(fan))
      else $error("locked fan changed");
   high_cause_a: assert property ($rose(local_high_status_o) |-> $past(local_conv_done_i))
      else $error("high status cause");
   low_cause_a: assert property ($rose(local_low_status_o) |-> $past(local_conv_done_i))
      else $error("low status cause");
   high_sticky_a: assert property (local_high_status_o && !status_clear_i
      |=> local_high_status_o) else $error("high status lost");
   alert_clear_a: assert property (status_clear_i && quiet |-> ##2 !alert_oe_o)
      else $error("alert after clear");
   cover property (sw_reset_i);
   cover property ($rose(alert_oe_o));
   cover property ($rose(local_low_status_o));
endmodule // fan_regs_properties

bind fan_source_alert_mask_regs fan_regs_properties chk (.*);

/* testbench/fan_source_alert_mask_regs_tb.sv */
// Purpose: Self-checking bench for the fan register slice
// Assumes: Host model owns the bus lines
// Notes:   Expected values queue up for the monitor
`timescale 1ns/1ps
module fan_source_alert_mask_regs_tb;
   import fan_regs_pkg::*;
   logic       clock_i = 0, rstn_i = 0, local_conv_done_i = 0, status_clear_i = 0, scl_i, hsda;
   logic       sw_reset_i = 0, config_lock_i = 0, alert_comparator_mode_i = 0, sda_oe_o;
   logic       alert_oe_o, fan_one_off_o, fan_two_off_o, fan_one_full_speed_o;
   logic       fan_two_full_speed_o, local_high_status_o, local_low_status_o;
   logic [1:0] fan_one_source_select_o, fan_two_source_select_o;
   logic [2:0] overtemp_event_i = 0, fan_fault_event_i = 0;
   logic [3:0] fault_queue_len_i = 0;
   logic [5:0] remote_event_i = 0;
   logic [7:0] local_temp_i = 0, got, v, h, q, exp_q[$];
   logic [7:0] rv[6] = '{8'h09, 8'h52, 8'h18, 8'h00, 8'h8B, 8'h54};
   int         err_count = 0, checks_done = 0;
   event       res_e;
   wire        sda_i = hsda & ~sda_oe_o;
   wire  [7:0] pins = {fan_two_off_o, fan_one_off_o, fan_two_source_select_o,
                       fan_one_source_select_o, fan_two_full_speed_o, fan_one_full_speed_o};
   wire  [7:0] st = {5'h00, local_high_status_o, local_low_status_o, alert_oe_o};
   fan_source_alert_mask_regs uut (.*, .sda_o(), .alert_o());
   smbus_host_model host (.clock_i, .sda_i, .scl_o(scl_i), .sda_o(hsda));
   always #4 clock_i = ~clock_i;
   always @(res_e) begin
      checks_done++;
      if (exp_q[0] !== got) begin
         err_count++;
         $display("Error at %0t: expected %h got %h", $time, exp_q[0], got);
      end
      void'(exp_q.pop_front());
   end
   task automatic ck(input logic [7:0] e, input logic [7:0] g);
      exp_q.push_back(e);
      got = g;
      -> res_e;
      @(posedge clock_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.xf(1'b1, a, 8'h00, q);
      ck(e, q);
   endtask
   // Conversion, status clear and event pulses, then settle
   task automatic pu(input logic c, input logic [7:0] t, input logic [6:0] e);
      {local_conv_done_i, local_temp_i, status_clear_i, overtemp_event_i, fan_fault_event_i} = {c, t, e};
      @(posedge clock_i);
      #1;
      {local_conv_done_i, status_clear_i, overtemp_event_i, fan_fault_event_i} = '0;
      repeat (3) @(posedge clock_i);
      #1;
   endtask
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #400_000;
      err_count++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h733f));
      repeat (8) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      foreach (rv[i]) rd(ADDR_FAN_BHV + 8'(i), rv[i]);
      $display("Reset test done");
      for (int c = 0; c < 4; c++) begin
         v = (8'($urandom) & 8'hF0) | 8'(c * 5);
         host.xf(1'b0, ADDR_FAN_BHV, v, q);
         rd(ADDR_FAN_BHV, v & 8'hCF);
         ck({v[7:6], v[3:0], &v[3:2], &v[1:0]}, pins);
      end
      for (int i = 1; i < 6; i++) host.xf(1'b0, ADDR_FAN_BHV + 8'(i), 8'hFF, q);
      rd(ADDR_MASK2, 8'h1C);
      rd(ADDR_MASK3, 8'hE0);
      config_lock_i = 1'b1;
      host.xf(1'b0, ADDR_FAN_BHV, ~v, q);
      host.xf(1'b0, ADDR_LOW_LIM, v, q);
      rd(ADDR_FAN_BHV, v & 8'hCF);
      sw_reset_i = 1'b1;
      @(posedge clock_i);
      #1;
      {sw_reset_i, config_lock_i} = 2'b00;
      rd(ADDR_FAN_BHV, 8'h09);
      rd(ADDR_MASK1, 8'h52);
      rd(ADDR_HIGH_LIM, 8'hFF);
      rd(ADDR_LOW_LIM, v);
      $display("Register test done");
      h = 8'h40 + 8'($urandom % 64);
      host.xf(1'b0, ADDR_HIGH_LIM, h, q);
      host.xf(1'b0, ADDR_LOW_LIM, h - 8'h10, q);
      fault_queue_len_i = 4'h8;
      pu(1'b0, h, 7'h40);
      pu(1'b1, h, '0);
      ck(8'h00, st);
      repeat (3) pu(1'b1, h + 8'h01, '0);
      ck(8'h04, st);
      pu(1'b1, h + 8'h01, '0);
      ck(8'h05, st);
      host.xf(1'b0, ADDR_MASK1, 8'h80, q);
      pu(1'b0, h, 7'h40);
      repeat (4) pu(1'b1, h + 8'h01, '0);
      ck(8'h04, st);
      fault_queue_len_i = 4'h0;
      pu(1'b1, h - 8'h11, '0);
      ck(8'h07, st);
      $display("Limit test done");
      host.xf(1'b0, ADDR_MASK1, 8'hFF, q);
      host.xf(1'b0, ADDR_MASK3, 8'h80, q);
      alert_comparator_mode_i = 1'b1;
      pu(1'b0, h, 7'h40);
      remote_event_i = 6'h3F;
      pu(1'b0, h, 7'h0C);
      remote_event_i = '0;
      ck(8'h00, st);
      alert_comparator_mode_i = 1'b0;
      pu(1'b0, h, 7'h08);
      ck(8'h01, st);
      pu(1'b0, h, 7'h40);
      pu(1'b0, h, 7'h02);
      ck(8'h01, st);
      $display("Event test done");
      end_sim();
   end
endmodule // fan_source_alert_mask_regs_tb
